// ==== hw/hsio_regs.sv ====
// Over-current report and start-up interlock registers with the start-up stage sequencer.
`timescale 1ns/1ps
`default_nettype none

module hsio_regs
  import hsio_pkg::*;
#(
  parameter int CFG_TMO_CYC = HSIO_CFG_TMO_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [3:1] host_port_power,
  input  wire logic       hub_connect,
  input  wire logic       chgdet_done,
  output logic      [3:1] overcurrent_flags,
  output logic      [3:1] port_power_status,
  output logic      [1:0] stage,
  output logic            cfg_write_ok
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0]  oc_q,    oc_d;
  logic [7:0]  il_q,    il_d;
  logic [7:0]  pwr_q,   pwr_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [31:0] tmo_q,   tmo_d;
  logic        il_wr_q, il_wr_d;
  logic        con_s1_q, con_s2_q;
  logic [2:0]  hp_s1_q, hp_s2_q;
  hsio_stage_t st_q,    st_d;

  // Write decode. A write to any other address, the read-only power status
  // word included, leaves both registers untouched.
  always_comb begin
    oc_d    = oc_q;
    il_d    = il_q;
    il_wr_d = il_wr_q;
    if (reg_wr && reg_addr == HSIO_OFF_OC_CTRL) begin
      oc_d = reg_wdata & HSIO_OC_MASK;
    end else if (reg_wr && reg_addr == HSIO_OFF_ILOCK_CTRL) begin
      il_d    = reg_wdata & HSIO_ILOCK_MASK;
      // Any interlock write, whatever its value, hands the exit from the
      // configuration stage to software and retires the timeout path.
      il_wr_d = 1'b1;
    end
  end

  // ****************************************************************
  // Read-back
  // ****************************************************************
  // The read word is registered, so it stands from the edge after the strobe
  // until the next read; a write in the same cycle is not yet reflected.
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      if (reg_addr == HSIO_OFF_OC_CTRL) begin
        rdata_d = oc_q;
      end else if (reg_addr == HSIO_OFF_ILOCK_CTRL) begin
        rdata_d = il_q;
      end else if (reg_addr == HSIO_OFF_PWR_STAT) begin
        rdata_d = pwr_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // ****************************************************************
  // Port power status
  // ****************************************************************
  // Host enable sets a power bit; an active over-current flag forces it low.
  // The next over-current value is used, not the current one, so that a new
  // flag and the cleared power bit appear at the same edge; otherwise both
  // would read one together for a cycle.
  always_comb begin
    pwr_d = {4'h0, hp_s2_q, 1'b0} & ~oc_d & HSIO_PWR_MASK;
  end

  // ****************************************************************
  // Start-up stage sequencer
  // ****************************************************************
  // The hub walks configuration, charger detect, connect and communication
  // in that order and never goes back short of a reset. The timeout counter
  // saturates at its limit so it cannot wrap and restart the stage.
  // Limitation: a hold-configure write that arrives after the timeout has
  // already expired is too late to keep the hub in configuration.
  always_comb begin
    st_d  = st_q;
    tmo_d = tmo_q;
    case (st_q)
      HSIO_ST_CONFIG: begin
        if (tmo_q < 32'(CFG_TMO_CYC)) begin
          tmo_d = tmo_q + 32'h1;
        end
        // Once software has written the interlock, only the hold-configure
        // bit decides; the timeout no longer forces an exit.
        if (il_wr_q) begin
          if (!il_q[HSIO_ILOCK_CFG_BIT]) begin
            st_d = HSIO_ST_CHGDET;
          end
        end else if (tmo_q >= 32'(CFG_TMO_CYC) - 32'h1) begin
          st_d = HSIO_ST_CHGDET;
        end
      end
      HSIO_ST_CHGDET: begin
        if (chgdet_done) begin
          st_d = HSIO_ST_CONNECT;
        end
      end
      HSIO_ST_CONNECT: begin
        // Either the cleared hold-connect bit or the synchronised connect
        // pin releases the stage; neither must wait for the other.
        if (!il_q[HSIO_ILOCK_CON_BIT] || con_s2_q) begin
          st_d = HSIO_ST_COMM;
        end
      end
      default: begin
        st_d = st_q;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      oc_q     <= HSIO_OC_RESET;
      il_q     <= HSIO_ILOCK_RESET;
      pwr_q    <= HSIO_PWR_RESET;
      rdata_q  <= 8'h00;
      tmo_q    <= 32'h0;
      il_wr_q  <= 1'b0;
      st_q     <= HSIO_ST_CONFIG;
    end else begin
      oc_q     <= oc_d;
      il_q     <= il_d;
      pwr_q    <= pwr_d;
      rdata_q  <= rdata_d;
      tmo_q    <= tmo_d;
      il_wr_q  <= il_wr_d;
      st_q     <= st_d;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // The connect pin and the host power enables come from outside this clock
  // domain. Only the second stage is read by any logic, so a metastable first
  // stage never reaches the sequencer or the power status.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      con_s1_q <= 1'b0;
      con_s2_q <= 1'b0;
      hp_s1_q  <= 3'h0;
      hp_s2_q  <= 3'h0;
    end else begin
      con_s1_q <= hub_connect;
      con_s2_q <= con_s1_q;
      hp_s1_q  <= host_port_power;
      hp_s2_q  <= hp_s1_q;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The stage and write-enable outputs load from the next state, so they
  // change at the same edge as the sequencer, except that the write enable resets low and rises only at the first edge after reset.
  // The flag copy likewise loads from the next register value, keeping it
  // in step with the power status that it clears.
  logic [3:1] ocf_q;
  logic [1:0] stage_q;
  logic       cwo_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ocf_q   <= 3'h0;
      stage_q <= 2'h0;
      cwo_q   <= 1'b0;
    end else begin
      ocf_q   <= oc_d[3:1];
      stage_q <= st_d;
      cwo_q   <= (st_d == HSIO_ST_CONFIG);
    end
  end

  assign reg_rdata         = rdata_q;
  assign overcurrent_flags = ocf_q;
  assign port_power_status = pwr_q[3:1];
  assign stage             = stage_q;
  assign cfg_write_ok      = cwo_q;

endmodule : hsio_regs

`default_nettype wire

// ==== hw/hsio_pkg.sv ====
// Package with register map, field positions, reset values and timing for the start-up interlock block.
package hsio_pkg;

  localparam logic [7:0] HSIO_OFF_OC_CTRL    = 8'he6;
  localparam logic [7:0] HSIO_OFF_ILOCK_CTRL = 8'he7;
  localparam logic [7:0] HSIO_OFF_PWR_STAT   = 8'he5;

  localparam logic [7:0] HSIO_OC_MASK        = 8'h0e;
  localparam logic [7:0] HSIO_ILOCK_MASK     = 8'h03;
  localparam logic [7:0] HSIO_PWR_MASK       = 8'h0e;
  localparam int         HSIO_ILOCK_CFG_BIT  = 0;
  localparam int         HSIO_ILOCK_CON_BIT  = 1;

  localparam logic [7:0] HSIO_OC_RESET       = 8'h00;
  localparam logic [7:0] HSIO_ILOCK_RESET    = 8'h00;
  localparam logic [7:0] HSIO_PWR_RESET      = 8'h00;

  // Configuration timeout in microseconds and the derived cycle count at 20 MHz.
  localparam int         HSIO_CLK_MHZ        = 20;
  localparam int         HSIO_CFG_TMO_US     = 1000;
  localparam int         HSIO_CFG_TMO_CYC    = HSIO_CFG_TMO_US * HSIO_CLK_MHZ;

  typedef enum logic [1:0] {
    HSIO_ST_CONFIG,
    HSIO_ST_CHGDET,
    HSIO_ST_CONNECT,
    HSIO_ST_COMM
  } hsio_stage_t;

endpackage : hsio_pkg

// ==== testbench/hsio_regs_monitor.sv ====
// Checker for the over-current and start-up interlock registers.
`timescale 1ns/1ps
`default_nettype none
module hsio_regs_monitor(input wire logic clk_sys, sys_rst, reg_wr, reg_rd, cfg_write_ok,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [3:1] overcurrent_flags, port_power_status, input wire logic [1:0] stage);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_oc; reg_wr&&reg_addr==8'he6 |=> overcurrent_flags==$past(reg_wdata[3:1]); endproperty
  a_oc: assert property(p_oc) else $error("oc");
  property p_pw; (port_power_status&overcurrent_flags)==3'h0; endproperty
  a_pw: assert property(p_pw) else $error("pw");
  property p_cr; reg_rd&&reg_addr==8'he7 |=> reg_rdata[7:2]==6'h0; endproperty
  a_cr: assert property(p_cr) else $error("cr");
  property p_un; reg_rd&&reg_addr>8'he7 |=> reg_rdata==8'h00; endproperty
  a_un: assert property(p_un) else $error("un");
  property p_cf; stage!=2'h0 |-> !cfg_write_ok; endproperty
  a_cf: assert property(p_cf) else $error("cf");
  sequence s_release; reg_wr&&reg_addr==8'he7&&!reg_wdata[0]&&stage==2'h0; endsequence
  property p_ch; s_release |-> ##[1:2] stage==2'h1; endproperty
  a_ch: assert property(p_ch) else $error("ch");
  property p_cs; stage==2'h0 |=> stage<=2'h1; endproperty
  a_cs: assert property(p_cs) else $error("cs");
  property p_cm; stage==2'h3 |=> stage==2'h3; endproperty
  a_cm: assert property(p_cm) else $error("cm");
endmodule : hsio_regs_monitor
bind hsio_regs hsio_regs_monitor u_mon(.*);
`default_nettype wire

// ==== testbench/hsio_host_model.sv ====
// Processor model that drives the register port.
`timescale 1ns/1ps
`default_nettype none
module hsio_host_model(input wire logic clk_sys, input wire logic [7:0] reg_rdata,
  output logic reg_wr, reg_rd, output logic [7:0] reg_addr, reg_wdata);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata}=18'h0;
  task wr(logic [7:0] a, d);
    @(posedge clk_sys) #1;
    {reg_addr, reg_wdata, reg_wr}={a, a==8'he6 ? d&8'h0f : d, 1'b1};
    @(posedge clk_sys) #1;
    {reg_wr, reg_wdata}={1'b0, ~reg_wdata};
  endtask : wr
  task rd(logic [7:0] a, output logic [7:0] q);
    @(posedge clk_sys) #1;
    {reg_addr, reg_rd}={a, 1'b1};
    @(posedge clk_sys) #1;
    {reg_rd, q}={1'b0, reg_rdata};
  endtask : rd
endmodule : hsio_host_model
`default_nettype wire

// ==== testbench/hsio_regs_test.sv ====
// Self-checking bench for the interlock registers.
`timescale 1ns/1ps
`default_nettype none
module hsio_regs_test;
  logic clk_sys=0, sys_rst=1, hub_connect=0, chgdet_done=0, reg_wr, reg_rd, cfg_write_ok;
  logic [3:1] host_port_power=0, overcurrent_flags, port_power_status;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q, d;
  logic [1:0] stage;
  logic [31:0] lf=32'hc73f;
  int errors=0, n_compared=0;
  always #25 clk_sys=~clk_sys;
  hsio_regs #(.CFG_TMO_CYC(20)) DUT(.*);
  hsio_host_model HM(.*);
  function logic [7:0] ex(logic oc); return oc ? d&8'h0e : {4'h0, host_port_power&~d[3:1], 1'b0}; endfunction : ex
  function logic [31:0] lfsr(logic [31:0] v); return {v[30:0], v[31]^v[21]^v[1]^v[0]}; endfunction : lfsr
  task ck(string s, logic [7:0] e, g);
    n_compared++;
    errors+=(g!==e);
    if (g!==e) $display("MISMATCH %s exp %h got %h", s, e, g);
  endtask : ck
  task rk(logic [7:0] a, e); HM.rd(a, q); ck("rdata", e, q); endtask : rk
  task sk(logic [1:0] s);
    for (int i=0; i<60 && stage!==s; i++) @(posedge clk_sys) #1;
    ck("stage", {6'h0, s}, {6'h0, stage});
  endtask : sk
  task rst; sys_rst=1; repeat (5) @(posedge clk_sys) #1; sys_rst=0; endtask : rst
  task test_done;
    if (errors==0 && n_compared>0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin #200us; errors++; test_done(); end
  initial begin
    rst();
    HM.wr(8'he7, 8'hff);
    rk(8'he7, 8'h03);
    #2000 sk(2'h0);
    ck("cfg_write_ok", 8'h01, {7'h0, cfg_write_ok});
    for (int i=0; i<8; i++) begin
      lf=lfsr(lf);
      d=i==0 ? 8'h0e : i==1 ? 8'h00 : lf[7:0];
      host_port_power=lf[10:8];
      HM.wr(8'he6, d);
      HM.wr(8'he5, ~d);
      rk(8'he6, ex(1'b1));
      rk(8'he5, ex(1'b0));
      ck("overcurrent_flags", {5'h0, d[3:1]}, {5'h0, overcurrent_flags});
      ck("port_power_status", ex(1'b0), {4'h0, port_power_status, 1'b0});
    end
    rk(8'hf0, 8'h00);
    HM.wr(8'he7, 8'h02);
    sk(2'h1);
    ck("cfg_write_ok", 8'h00, {7'h0, cfg_write_ok});
    chgdet_done=1;
    #1000 sk(2'h2);
    hub_connect=1;
    sk(2'h3);
    hub_connect=0;
    rst();
    #500 sk(2'h0);
    sk(2'h3);
    test_done();
  end
endmodule : hsio_regs_test
`default_nettype wire
